// ==== logic/lvdt_core_regs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef LVDT_CORE_REGS_SVH
`define LVDT_CORE_REGS_SVH
`define REG_CTRL 8'h00
`define REG_PERIOD 8'h04
`define REG_STATUS 8'h08
`define REG_FAULT 8'h0c
`define REG_ODDATA 8'h10
`define REG_RESULT 8'h20
`define CTRL_RUN 0
`define CTRL_SINGLE 1
`define CTRL_FRONT_DRIVE 2
`define CTRL_EDGE_FALL 3
`define CTRL_USE_TRIG 4
`define CTRL_OD_REQ 5
`define CTRL_OC_EN_LSB 8
`define FAULT_OPEN_LSB 0
`define FAULT_HIZ_LSB 4
`define FAULT_OC_LSB 8
`define CTRL_RESET 16'h0000
`define PERIOD_RESET 24'h0186a0
`define MCLK_HZ 10000000
`define RATE_MAX_MHZ 25600000
`define RATE_MIN_MHZ 1000
`define LOOSE_RATE_HZ 25
`define OC_OFF_MS 1000
`endif

// ==== logic/lvdt_core_pkg.sv ====
// Types shared by the acquisition core
package lvdt_core_pkg;
    typedef enum {ACQ_IDLE, ACQ_ARMED, ACQ_WAIT_CLK, ACQ_RUN} acq_state_t;
    typedef logic signed [23:0] sample_t;
endpackage

// ==== logic/lvdt_demod_acquisition_core.sv ====
// Four-channel demodulating acquisition core with fault monitoring
`timescale 1ns/1ps
`default_nettype none
`include "lvdt_core_regs.svh"

module lvdt_demod_acquisition_core #(
    parameter int NCH = 4,
    parameter int OSR_DIV = 40,
    parameter int DEMOD_LEN = 8,
    parameter int LOOSE_CAP = 64,
    parameter int OC_OFF_CYCLES = (`MCLK_HZ / 1000) * `OC_OFF_MS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Converters
    output logic convStart,
    input wire logic convValid,
    input wire logic [NCH*24-1:0] convSec,
    input wire logic [NCH*24-1:0] convPri,
    // Fault sense pins
    output logic [NCH-1:0] openCoilEn,
    input wire logic [NCH-1:0] openCoilDet,
    input wire logic [NCH-1:0] exHiZ,
    input wire logic [NCH-1:0] exOverCur,
    output logic [NCH-1:0] relayClosed,
    // Front trigger line
    input wire logic frontTrigIn,
    output logic frontTrigOut,
    output logic frontTrigOe_n,
    // Sample clock and results
    output logic sampleClkOut,
    output logic resultValid,
    output logic [NCH*24-1:0] resultData
);
    import lvdt_core_pkg::*;

    localparam int DEMOD_CYC = OSR_DIV * DEMOD_LEN;
    localparam logic [23:0] MIN_PERIOD = 24'((`MCLK_HZ * 64'd1000 + `RATE_MAX_MHZ - 1)
        / `RATE_MAX_MHZ);
    localparam logic [23:0] MAX_PERIOD = 24'(`MCLK_HZ * 64'd1000 / `RATE_MIN_MHZ);
    localparam logic [23:0] LOOSE_PERIOD = 24'(`MCLK_HZ / `LOOSE_RATE_HZ);

    // Decimation factor from period; one demod sample means full demod bandwidth
    function automatic logic [23:0] neff_f(input logic [23:0] per);
        logic [23:0] n;
        n = per / 24'(DEMOD_CYC);
        if (n == 24'h0) n = 24'h1;
        if (per > LOOSE_PERIOD && n > 24'(LOOSE_CAP)) n = 24'(LOOSE_CAP);
        return n;
    endfunction

    // Group delay in mclk cycles
    function automatic logic [23:0] gdel_f(input logic [23:0] per, input logic single);
        logic [23:0] d;
        d = 24'(DEMOD_CYC);
        if (!single) d = d + 24'(neff_f(per) * 24'(DEMOD_CYC));
        return d;
    endfunction

    // Synchronisers for pin inputs
    logic [NCH-1:0] openS1_r, openS2_r, hizS1_r, hizS2_r, ocS1_r, ocS2_r;
    logic trigS1_r, trigS2_r, trigD_r;
    always_ff @(posedge mclk) begin
        openS1_r <= openCoilDet;
        openS2_r <= openS1_r;
        hizS1_r <= exHiZ;
        hizS2_r <= hizS1_r;
        ocS1_r <= exOverCur;
        ocS2_r <= ocS1_r;
        trigS1_r <= frontTrigIn;
        trigS2_r <= trigS1_r;
        trigD_r <= trigS2_r;
    end

    // Register decode
    logic [15:0] ctrl_r;
    logic [23:0] period_r;
    logic [3*NCH-1:0] fault_r;
    logic odDone_r, overrun_r;
    logic [NCH*24-1:0] odData_r;
    wire selCtrl = (regAddr == `REG_CTRL);
    wire selPeriod = (regAddr == `REG_PERIOD);
    wire selStatus = (regAddr == `REG_STATUS);
    wire selFault = (regAddr == `REG_FAULT);
    wire selOd = (regAddr[7:4] == `REG_ODDATA >> 4) && (regAddr[1:0] == 2'b00);
    wire selRes = (regAddr[7:4] == `REG_RESULT >> 4) && (regAddr[1:0] == 2'b00);
    wire [1:0] chSel = regAddr[3:2];
    wire wrCtrl = regWr && selCtrl;
    wire runEn = ctrl_r[`CTRL_RUN];
    wire singleMode = ctrl_r[`CTRL_SINGLE];
    wire frontDrive = ctrl_r[`CTRL_FRONT_DRIVE];
    wire odReq = wrCtrl && regWdata[`CTRL_OD_REQ];
    wire [23:0] perClamp = (regWdata[23:0] < MIN_PERIOD) ? MIN_PERIOD :
        (regWdata[23:0] > MAX_PERIOD) ? MAX_PERIOD : regWdata[23:0];

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_r <= `CTRL_RESET;
            period_r <= `PERIOD_RESET;
        end else begin
            if (wrCtrl) ctrl_r <= {regWdata[15:6], 1'b0, regWdata[4:0]};
            if (regWr && selPeriod) period_r <= perClamp;
        end
    end

    assign openCoilEn = ctrl_r[`CTRL_OC_EN_LSB +: NCH];

    // Front line: drive sample clock out or receive a trigger
    assign frontTrigOe_n = !frontDrive;
    assign frontTrigOut = frontDrive ? sampleClkOut : 1'b0;
    wire trigEdge = !frontDrive && (ctrl_r[`CTRL_EDGE_FALL] ?
        (trigD_r && !trigS2_r) : (!trigD_r && trigS2_r));

    // Overcurrent relay hold-off
    logic [31:0] ocCnt_r [NCH];
    always_ff @(posedge mclk) begin
        for (int i = 0; i < NCH; i++) begin
            if (rst) ocCnt_r[i] <= 32'h0;
            else if (ocS2_r[i]) ocCnt_r[i] <= 32'(OC_OFF_CYCLES);
            else if (ocCnt_r[i] != 32'h0) ocCnt_r[i] <= ocCnt_r[i] - 32'h1;
        end
    end
    always_comb begin
        for (int i = 0; i < NCH; i++) relayClosed[i] = (ocCnt_r[i] == 32'h0);
    end

    // Sticky faults, write one to clear; a new event wins over the clear
    wire [3*NCH-1:0] faultSet = {ocS2_r, hizS2_r, openS2_r & openCoilEn};
    wire [3*NCH-1:0] faultClr = (regWr && selFault) ? regWdata[3*NCH-1:0] : '0;
    always_ff @(posedge mclk) begin
        if (rst) fault_r <= '0;
        else fault_r <= (fault_r & ~faultClr) | faultSet;
    end

    // Common conversion start for all converters
    logic [15:0] convCnt_r;
    always_ff @(posedge mclk) begin
        if (rst || convCnt_r == 16'(OSR_DIV - 1)) convCnt_r <= 16'h0;
        else convCnt_r <= convCnt_r + 16'h1;
    end
    assign convStart = (convCnt_r == 16'h0);

    // Synchronous demodulation by integrate-and-dump
    logic signed [39:0] secAcc_r [NCH];
    logic [39:0] priAcc_r [NCH];
    sample_t demod_r [NCH];
    logic [7:0] demCnt_r;
    logic demodStb_r;
    wire demDump = convValid && (demCnt_r == 8'(DEMOD_LEN - 1));
    always_ff @(posedge mclk) begin
        if (rst) begin
            demCnt_r <= 8'h0;
            demodStb_r <= 1'b0;
            for (int i = 0; i < NCH; i++) begin
                secAcc_r[i] <= '0;
                priAcc_r[i] <= '0;
                demod_r[i] <= '0;
            end
        end else begin
            demodStb_r <= demDump;
            if (convValid) demCnt_r <= demDump ? 8'h0 : demCnt_r + 8'h1;
            for (int i = 0; i < NCH; i++) begin
                if (convValid) begin
                    // Folding by primary polarity carries phase into the sign
                    secAcc_r[i] <= (demDump ? 40'sh0 : secAcc_r[i]) +
                        (convPri[i*24+23] ? -40'(signed'(convSec[i*24 +: 24])) :
                        40'(signed'(convSec[i*24 +: 24])));
                    priAcc_r[i] <= (demDump ? 40'h0 : priAcc_r[i]) +
                        (convPri[i*24+23] ? 40'(-signed'(convPri[i*24 +: 24])) :
                        40'(convPri[i*24 +: 24]));
                end
                if (demDump) demod_r[i] <= ratio_f(secAcc_r[i], priAcc_r[i]);
            end
        end
    end

    // Ratio scaled so unity is 2^22, saturated; zero primary reads zero
    function automatic sample_t ratio_f(input logic signed [39:0] s, input logic [39:0] p);
        logic signed [63:0] q;
        q = 64'sh0;
        if (p != 40'h0) q = (64'(s) <<< 22) / signed'({24'h0, p});
        if (q > 64'sh7fffff) q = 64'sh7fffff;
        if (q < -64'sh800000) q = -64'sh800000;
        return sample_t'(q[23:0]);
    endfunction

    // Buffered-mode decimating average filter
    logic signed [47:0] decAcc_r [NCH];
    sample_t decOut_r [NCH];
    logic [23:0] decCnt_r;
    wire [23:0] nEff = neff_f(period_r);
    wire decDump = demodStb_r && (decCnt_r >= nEff - 24'h1);
    always_ff @(posedge mclk) begin
        if (rst || singleMode) begin
            decCnt_r <= 24'h0;
            for (int i = 0; i < NCH; i++) begin
                decAcc_r[i] <= '0;
                decOut_r[i] <= '0;
            end
        end else if (demodStb_r) begin
            decCnt_r <= decDump ? 24'h0 : decCnt_r + 24'h1;
            for (int i = 0; i < NCH; i++) begin
                decAcc_r[i] <= decDump ? 48'sh0 : decAcc_r[i] + 48'(demod_r[i]);
                if (decDump) decOut_r[i] <= sample_t'((decAcc_r[i] + 48'(demod_r[i]))
                    / signed'({24'h0, nEff}));
            end
        end
    end

    // Sample clock generator
    logic [23:0] sampCnt_r;
    acq_state_t state_r, state_nxt;
    wire sampTick = (state_r != ACQ_IDLE) && (sampCnt_r == 24'h0);
    always_ff @(posedge mclk) begin
        if (rst || state_r == ACQ_IDLE || sampCnt_r == 24'h0)
            sampCnt_r <= period_r - 24'h1;
        else sampCnt_r <= sampCnt_r - 24'h1;
    end
    // Pulse marks the converter-input instant, ahead of filtered data
    always_ff @(posedge mclk) sampleClkOut <= rst ? 1'b0 : sampTick;

    // Start sequencing relative to sample clock edges
    wire startTrig = trigEdge || !ctrl_r[`CTRL_USE_TRIG];
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ACQ_IDLE: if (runEn) state_nxt = ACQ_ARMED;
            ACQ_ARMED: if (startTrig) state_nxt = ACQ_WAIT_CLK;
            ACQ_WAIT_CLK: if (sampTick) state_nxt = ACQ_RUN;
            ACQ_RUN: state_nxt = ACQ_RUN;
            default: state_nxt = ACQ_IDLE;
        endcase
        if (!runEn) state_nxt = ACQ_IDLE;
    end
    always_ff @(posedge mclk) state_r <= rst ? ACQ_IDLE : state_nxt;
    wire takeSample = sampTick && (state_r == ACQ_WAIT_CLK || state_r == ACQ_RUN);

    // Release timestamps for pending samples
    logic [23:0] timer_r;
    logic [23:0] relTime_r [4];
    logic [2:0] pendCnt_r;
    logic [1:0] wrPtr_r, rdPtr_r;
    wire relNow = (pendCnt_r != 3'h0) && (timer_r == relTime_r[rdPtr_r]);
    wire push = takeSample && (pendCnt_r != 3'h4);
    always_ff @(posedge mclk) begin
        if (rst || !runEn) begin
            timer_r <= 24'h0;
            pendCnt_r <= 3'h0;
            wrPtr_r <= 2'h0;
            rdPtr_r <= 2'h0;
            overrun_r <= rst ? 1'b0 : overrun_r;
            for (int i = 0; i < 4; i++) relTime_r[i] <= 24'h0;
        end else begin
            timer_r <= timer_r + 24'h1;
            if (push) begin
                relTime_r[wrPtr_r] <= timer_r + gdel_f(period_r, singleMode);
                wrPtr_r <= wrPtr_r + 2'h1;
            end
            if (relNow) rdPtr_r <= rdPtr_r + 2'h1;
            pendCnt_r <= pendCnt_r + {2'h0, push} - {2'h0, relNow};
            // Too many samples in flight: newest is dropped and flagged
            if (takeSample && !push) overrun_r <= 1'b1;
        end
    end

    // Result hand-over, one word set per sample taken after start
    always_ff @(posedge mclk) begin
        if (rst) begin
            resultValid <= 1'b0;
            resultData <= '0;
        end else begin
            resultValid <= relNow;
            if (relNow) begin
                for (int i = 0; i < NCH; i++)
                    resultData[i*24 +: 24] <= singleMode ? demod_r[i] : decOut_r[i];
            end
        end
    end

    // On-demand read at maximum rate, returned after full group delay
    logic [23:0] odCnt_r, odLeft_r;
    logic odWait_r, odHold_r;
    always_ff @(posedge mclk) begin
        if (rst) begin
            odCnt_r <= 24'h0;
            odLeft_r <= 24'h0;
            odWait_r <= 1'b0;
            odHold_r <= 1'b0;
            odDone_r <= 1'b0;
            odData_r <= '0;
        end else begin
            odCnt_r <= (odCnt_r == 24'h0) ? MIN_PERIOD - 24'h1 : odCnt_r - 24'h1;
            if (odReq) begin
                odWait_r <= 1'b1;
                odDone_r <= 1'b0;
            end else if (odWait_r && odCnt_r == 24'h0) begin
                odWait_r <= 1'b0;
                odHold_r <= 1'b1;
                odLeft_r <= gdel_f(MIN_PERIOD, 1'b0);
            end else if (odHold_r) begin
                if (odLeft_r == 24'h0) begin
                    odHold_r <= 1'b0;
                    odDone_r <= 1'b1;
                    for (int i = 0; i < NCH; i++) odData_r[i*24 +: 24] <= demod_r[i];
                end else odLeft_r <= odLeft_r - 24'h1;
            end
        end
    end

    // Read data, one cycle after the strobe
    wire [31:0] statusWord = {20'h0, relayClosed, 1'b0, overrun_r, odDone_r,
        odWait_r | odHold_r, 2'(state_r), 2'h0};
    wire [31:0] rdMux = selCtrl ? {16'h0, ctrl_r} :
        selPeriod ? {8'h0, period_r} :
        selStatus ? statusWord :
        selFault ? {20'h0, fault_r} :
        selOd ? {{8{odData_r[chSel*24+23]}}, odData_r[chSel*24 +: 24]} :
        selRes ? {{8{resultData[chSel*24+23]}}, resultData[chSel*24 +: 24]} : 32'h0;
    always_ff @(posedge mclk) regRdata <= (rst || !regRd) ? 32'h0 : rdMux;

endmodule // lvdt_demod_acquisition_core
`default_nettype wire

// ==== tb/lvdt_core_chk_sva.sv ====
// Port-level assertion checker for the acquisition core
`timescale 1ns/1ps
`default_nettype none
module lvdt_core_chk #(
    parameter int NCH = 4,
    parameter int OSR_DIV = 40,
    parameter int OC_OFF_CYCLES = 100
) (
    // Clock, reset and register port
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    // Design outputs and fault pins
    input wire logic convStart,
    input wire logic [NCH-1:0] openCoilEn,
    input wire logic [NCH-1:0] exOverCur,
    input wire logic [NCH-1:0] relayClosed,
    input wire logic frontTrigOut,
    input wire logic frontTrigOe_n,
    input wire logic sampleClkOut,
    input wire logic resultValid
);
    logic single_r;
    logic run_r;
    logic [9:0] sclkCnt_r;
    logic [31:0] ocLow_r;
    wire logic ctrlWr = regWr && regAddr == 8'h00;
    wire logic cntLive = sclkCnt_r != 10'h0 && sclkCnt_r < 10'h3e8;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    always_ff @(posedge mclk) begin
        if (rst) begin
            single_r <= 1'b0;
            run_r <= 1'b0;
            sclkCnt_r <= 10'h0;
            ocLow_r <= 32'h0;
        end else begin
            if (ctrlWr) begin
                single_r <= regWdata[1];
                run_r <= regWdata[0];
            end
            // Drops back to zero after 1000 so a stale count cannot wrap into a false match
            sclkCnt_r <= sampleClkOut ? 10'h1 : (cntLive ? sclkCnt_r + 10'h1 : 10'h0);
            ocLow_r <= (!relayClosed[0] && !exOverCur[0]) ? ocLow_r + 32'h1 : 32'h0;
        end
    end
    conv_period_a: assert property (convStart |-> ##OSR_DIV convStart)
        else $error("converter start spacing wrong");
    oc_en_a: assert property (ctrlWr |=> openCoilEn == $past(regWdata[11:8]))
        else $error("open-coil enables do not follow control");
    relay_open_a: assert property (exOverCur[0] [*5] |-> !relayClosed[0])
        else $error("relay still closed under overcurrent");
    relay_hold_a: assert property ($fell(relayClosed[0]) |=> !relayClosed[0] [*8])
        else $error("relay reclosed too early");
    relay_back_a: assert property ($rose(relayClosed[0]) |-> ocLow_r >= OC_OFF_CYCLES - 2)
        else $error("relay off time too short");
    relay_bound_a: assert property (ocLow_r <= OC_OFF_CYCLES + 8)
        else $error("relay not restored in time");
    delay_single_a: assert property (single_r && run_r && sclkCnt_r == 10'h140 |-> resultValid)
        else $error("single-point result not on time");
    result_pair_a: assert property (single_r && run_r && resultValid |-> sclkCnt_r == 10'h140)
        else $error("result without matching sample clock");
    oe_ctrl_a: assert property (ctrlWr |=> frontTrigOe_n == !$past(regWdata[2]))
        else $error("front line direction wrong");
    trig_copy_a: assert property (frontTrigOut == (!frontTrigOe_n && sampleClkOut))
        else $error("front line output wrong");
    cover property (single_r && resultValid);
    cover property ($fell(relayClosed[0]));
    cover property (!frontTrigOe_n && frontTrigOut);
endmodule // lvdt_core_chk
`default_nettype wire

// ==== tb/conv_model.sv ====
// Behavioural model of the converter bank feeding the core
`timescale 1ns/1ps
`default_nettype none
module conv_model #(
    parameter int NCH = 4,
    parameter int LAT = 5
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Converter handshake and words
    input wire logic convStart,
    output logic convValid,
    output logic [NCH*24-1:0] convSec,
    output logic [NCH*24-1:0] convPri
);
    int cnt;
    logic [NCH*24-1:0] secWord;
    logic [NCH*24-1:0] priWord;
    // Odd channels see inverted primary phase
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            secWord[i*24+:24] = 24'h100000;
            priWord[i*24+:24] = i[0] ? 24'he00000 : 24'h200000;
        end
    end
    // One start feeds every converter; all words land together
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt <= 0;
            convValid <= 1'b0;
            convSec <= '0;
            convPri <= '0;
        end else begin
            cnt <= convStart ? LAT : (cnt > 0 ? cnt - 1 : 0);
            convValid <= cnt == 1;
            // Lines toggle outside valid so stale data cannot pass as good
            convSec <= cnt == 1 ? secWord : ~convSec;
            convPri <= cnt == 1 ? priWord : ~convPri;
        end
    end
endmodule // conv_model
`default_nettype wire

// ==== tb/lvdt_demod_acquisition_core_tb_top.sv ====
// Self-checking testbench for the acquisition core
`timescale 1ns/1ps
`default_nettype none
module lvdt_demod_acquisition_core_tb_top;
    import lvdt_core_pkg::*;
    localparam int NCH = 4;
    localparam int OC_OFF = 100;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic frontTrigIn = 1'b0;
    logic [NCH-1:0] openCoilDet = 4'h0;
    logic [NCH-1:0] exHiZ = 4'h0;
    logic [NCH-1:0] exOverCur = 4'h0;
    wire logic [31:0] regRdata;
    wire logic convStart, convValid, frontTrigOut, frontTrigOe_n, sampleClkOut, resultValid;
    wire logic [NCH*24-1:0] convSec, convPri, resultData;
    wire logic [NCH-1:0] openCoilEn, relayClosed;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    int dWait, dLat, nClk, nRes, nTrg, n;
    logic [31:0] rd;
    always #50 mclk = ~mclk;
    lvdt_demod_acquisition_core #(.OC_OFF_CYCLES(OC_OFF)) i_dut (.mclk, .rst, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .convStart, .convValid, .convSec, .convPri,
        .openCoilEn, .openCoilDet, .exHiZ, .exOverCur, .relayClosed, .frontTrigIn,
        .frontTrigOut, .frontTrigOe_n, .sampleClkOut, .resultValid, .resultData);
    conv_model #(.NCH(NCH), .LAT(5)) i_conv (.mclk, .rst, .convStart, .convValid, .convSec,
        .convPri);
    task automatic end_of_test();
        $display("compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rdr(input logic [7:0] a);
        @(posedge mclk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        rd = regRdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rdr(a);
        check(rd, exp);
    endtask
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic measure();
        dWait = 0;
        dLat = 0;
        while (sampleClkOut !== 1'b1 && dWait < 3000) begin
            tick();
            dWait++;
        end
        while (resultValid !== 1'b1 && dLat < 3000) begin
            tick();
            dLat++;
        end
    endtask
    task automatic count(input int len);
        nClk = 0;
        nRes = 0;
        nTrg = 0;
        repeat (len) begin
            tick();
            if (sampleClkOut === 1'b1) nClk++;
            if (frontTrigOut === 1'b1) nTrg++;
            if (resultValid === 1'b1) nRes++;
        end
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rchk(8'h00, 32'h0);
        rchk(8'h04, 32'h186a0);
        rchk(8'h08, 32'hf00);
        rchk(8'h40, 32'h0);
        wr(8'h08, 32'h0);
        rchk(8'h08, 32'hf00);
        wr(8'h04, 32'h1);
        rchk(8'h04, 32'h187);
        wr(8'h04, 32'hffffff);
        rchk(8'h04, 32'h989680);
        $display("register test done");
        wr(8'h00, 32'h200);
        openCoilDet <= 4'h3;
        exHiZ <= 4'h4;
        repeat (6) @(posedge mclk);
        openCoilDet <= 4'h0;
        exHiZ <= 4'h0;
        repeat (6) @(posedge mclk);
        rchk(8'h0c, 32'h42);
        wr(8'h0c, 32'hfff);
        rchk(8'h0c, 32'h0);
        @(posedge mclk);
        exOverCur <= 4'h1;
        repeat (5) @(posedge mclk);
        exOverCur <= 4'h0;
        rchk(8'h0c, 32'h100);
        rdr(8'h08);
        check({28'h0, rd[11:8]}, 32'he);
        repeat (OC_OFF + 20) @(posedge mclk);
        rdr(8'h08);
        check({28'h0, rd[11:8]}, 32'hf);
        wr(8'h0c, 32'h100);
        $display("fault test done");
        wr(8'h04, 32'h190);
        wr(8'h00, 32'h7);
        measure();
        check(dLat, 32'd320);
        for (int i = 0; i < NCH; i++) begin
            check({8'h0, resultData[i*24+:24]}, i[0] ? 32'he00000 : 32'h200000);
        end
        check({31'h0, frontTrigOe_n}, 32'h0);
        rchk(8'h24, 32'hffe00000);
        count(1600);
        check(nClk, 32'd4);
        check(nRes, 32'd4);
        check(nTrg, 32'd4);
        $display("single-point test done");
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h11);
        // Sample clock already runs while armed, so a trigger has edges to refer to
        count(500);
        check(nClk, 32'd1);
        check(nRes, 32'd0);
        check(nTrg, 32'd0);
        rdr(8'h08);
        check({30'h0, rd[3:2]}, 32'h1);
        check({31'h0, frontTrigOe_n}, 32'h1);
        @(posedge mclk);
        frontTrigIn <= 1'b1;
        repeat (5) @(posedge mclk);
        frontTrigIn <= 1'b0;
        measure();
        check({31'h0, dWait <= 410}, 32'h1);
        check(dLat, 32'd640);
        $display("triggered buffered test done");
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h20);
        n = 0;
        rd = 32'h0;
        while (rd[5] !== 1'b1 && n < 2000) begin
            rdr(8'h08);
            n += 2;
        end
        check({31'h0, n >= 641 && n <= 1100}, 32'h1);
        rchk(8'h10, 32'h200000);
        $display("on-demand test done");
        end_of_test();
    end
endmodule // lvdt_demod_acquisition_core_tb_top
bind lvdt_demod_acquisition_core lvdt_core_chk #(.NCH(NCH), .OSR_DIV(OSR_DIV),
    .OC_OFF_CYCLES(OC_OFF_CYCLES)) i_chk (.mclk, .rst, .regAddr, .regWdata, .regWr,
    .convStart, .openCoilEn, .exOverCur, .relayClosed, .frontTrigOut, .frontTrigOe_n,
    .sampleClkOut, .resultValid);
`default_nettype wire
